// ---- gsncr_regs.sv ----
// global configuration and status register bank of the motor controller
//
// Notes on behaviour
// - reset sets flag zero, restores all registers
// - host clears a flag by writing one
// - driver error flag; clears only when cool
// - undervoltage flag latches; driver off while undervoltage present
// - uart writes count in 8-bit counter
// - reads keep counter; no counting in spi
// - counter wraps from maximum to zero
// - node address field, reset value zero
// - address pin adds one to address
// - reply delay 8 to 120 bit times
// - pin snapshot shows eight input levels
// - bit six reads external step source
// - top byte holds read-only version code
// - bit zero sets chain output polarity
// - pulse high while position equals compare
// - each write with otp byte field zero made while no burn runs burns one selected otp bit
// - read of otp register made while no burn runs refreshes data
`timescale 1ns/10ps
`include "gsncr_map.svh"

module gsncr_regs import gsncr_pkg::*; #(
  // arbitrary value, not tied to any real part
  parameter logic [7:0] VERSION_CODE = 8'h01,
  parameter int OTP_BIT_PROGRAMMER_CYCLES = `GSNCR_OTP_BIT_PROGRAMMER_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic uart_mode,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`GSNCR_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rdata_valid,
  input wire logic [7:0] input_pins,
  input wire logic address_increment_pin,
  input wire logic driver_shutdown_event,
  input wire logic temp_below_limit,
  input wire logic charge_pump_undervoltage,
  input wire logic [31:0] actual_position,
  output logic [7:0] uart_effective_address,
  output logic [6:0] reply_delay_bits,
  output logic driver_enable,
  output logic chain_next_address_out,
  output logic chain_next_address_oe,
  output logic second_diagnostic_output,
  output logic [7:0] otp_read_data,
  output logic otp_busy
);

  // ========================================================================
  // pin synchronisers
  // all pin levels and analog events come from outside the clock domain
  logic [11:0] meta_q, meta_d;
  logic [11:0] sync_q, sync_d;
  logic [7:0] pins_s;
  logic inc_s;
  logic shutdown_s;
  logic temp_low_s;
  logic cp_uv_s;

  always_comb begin
    meta_d = {charge_pump_undervoltage, temp_below_limit,
              driver_shutdown_event, address_increment_pin, input_pins};
    sync_d = meta_q;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_q <= 12'h000;
      sync_q <= 12'h000;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign pins_s = sync_q[7:0];
  assign inc_s = sync_q[8];
  assign shutdown_s = sync_q[9];
  assign temp_low_s = sync_q[10];
  assign cp_uv_s = sync_q[11];

  // ========================================================================
  // address decode
  logic wr_flags;
  logic wr_node;
  logic wr_pol;
  logic wr_cmp;
  logic wr_otp;
  logic rd_otp;

  assign wr_flags = reg_wr && (reg_addr == `GSNCR_ADDR_STATUS_FLAGS);
  assign wr_node = reg_wr && (reg_addr == `GSNCR_ADDR_NODE_CFG);
  // the pin snapshot offset doubles as the polarity register on writes
  assign wr_pol = reg_wr && (reg_addr == `GSNCR_ADDR_PIN_SNAP);
  assign wr_cmp = reg_wr && (reg_addr == `GSNCR_ADDR_POS_CMP);
  assign wr_otp = reg_wr && (reg_addr == `GSNCR_ADDR_OTP_BIT_PROGRAMMER);
  assign rd_otp = reg_rd && (reg_addr == `GSNCR_ADDR_OTP_BIT_PROGRAMMER);

  // ========================================================================
  // global status flags
  logic [2:0] flags_q, flags_d;
  logic [2:0] flag_clr;

  // set wins over a clear arriving in the same cycle
  always_comb begin
    flag_clr = wr_flags ? reg_wdata[2:0] : 3'h0;
    flags_d = flags_q;
    if (flag_clr[`GSNCR_FLAG_RESET]) begin
      flags_d[`GSNCR_FLAG_RESET] = 1'b0;
    end
    // a hot bridge refuses the clear so the error cannot be hidden
    if (flag_clr[`GSNCR_FLAG_DRV_ERR] && temp_low_s) begin
      flags_d[`GSNCR_FLAG_DRV_ERR] = 1'b0;
    end
    if (shutdown_s) begin
      flags_d[`GSNCR_FLAG_DRV_ERR] = 1'b1;
    end
    if (flag_clr[`GSNCR_FLAG_CP_UV]) begin
      flags_d[`GSNCR_FLAG_CP_UV] = 1'b0;
    end
    if (cp_uv_s) begin
      flags_d[`GSNCR_FLAG_CP_UV] = 1'b1;
    end
  end

  // reset value carries the reset-seen flag set
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flags_q <= `GSNCR_FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ========================================================================
  // uart write counter
  logic [7:0] cnt_q, cnt_d;

  // reads never touch it; spi traffic is not counted; 8 bits wrap freely
  always_comb begin
    cnt_d = cnt_q;
    if (reg_wr && uart_mode) begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= `GSNCR_CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ========================================================================
  // node configuration, chain polarity and compare value
  logic [7:0] node_addr_q, node_addr_d;
  logic [3:0] delay_q, delay_d;
  logic pol_q, pol_d;
  logic [31:0] cmp_q, cmp_d;

  // address 255 would overflow on increment; the host avoids it
  always_comb begin
    node_addr_d = node_addr_q;
    delay_d = delay_q;
    pol_d = pol_q;
    cmp_d = cmp_q;
    if (wr_node) begin
      node_addr_d = reg_wdata[`GSNCR_NODE_ADDR_MSB:0];
      delay_d = reg_wdata[`GSNCR_DELAY_MSB:`GSNCR_DELAY_LSB];
    end
    if (wr_pol) begin
      pol_d = reg_wdata[`GSNCR_POL_BIT];
    end
    if (wr_cmp) begin
      cmp_d = reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      node_addr_q <= `GSNCR_NODE_ADDR_RST;
      delay_q <= `GSNCR_DELAY_RST;
      pol_q <= `GSNCR_POLARITY_RST;
      cmp_q <= `GSNCR_CMP_RST;
    end else begin
      node_addr_q <= node_addr_d;
      delay_q <= delay_d;
      pol_q <= pol_d;
      cmp_q <= cmp_d;
    end
  end

  // ========================================================================
  // derived outputs, all from flops
  logic [7:0] eff_addr_q, eff_addr_d;
  logic [6:0] delay_bits_q, delay_bits_d;
  logic drv_en_q, drv_en_d;
  logic chain_q, chain_d;
  logic chain_oe_q, chain_oe_d;
  logic pulse_q, pulse_d;

  always_comb begin
    eff_addr_d = node_addr_q + {7'h00, inc_s};
    // code pairs share a step: odd multiple of eight bit times
    delay_bits_d = {delay_q[3:1], 1'b1, 3'h0};
    // the driver stays off while the pump is low or an error is latched
    drv_en_d = !cp_uv_s && !flags_q[`GSNCR_FLAG_DRV_ERR];
    chain_d = pol_q;
    // the serial-out pin is only ours in uart mode; spi owns it otherwise
    chain_oe_d = uart_mode;
    pulse_d = (actual_position == cmp_q);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      eff_addr_q <= `GSNCR_NODE_ADDR_RST;
      delay_bits_q <= 7'h00;
      drv_en_q <= 1'b0;
      chain_q <= `GSNCR_POLARITY_RST;
      chain_oe_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      eff_addr_q <= eff_addr_d;
      delay_bits_q <= delay_bits_d;
      drv_en_q <= drv_en_d;
      chain_q <= chain_d;
      chain_oe_q <= chain_oe_d;
      pulse_q <= pulse_d;
    end
  end

  assign uart_effective_address = eff_addr_q;
  assign reply_delay_bits = delay_bits_q;
  assign driver_enable = drv_en_q;
  assign chain_next_address_out = chain_q;
  assign chain_next_address_oe = chain_oe_q;
  assign second_diagnostic_output = pulse_q;

  // ========================================================================
  // otp programmer
  gsncr_otp_if otp_bus();

  assign otp_bus.prog_req = wr_otp;
  assign otp_bus.refresh_req = rd_otp;
  assign otp_bus.bit_sel = reg_wdata[`GSNCR_OTP_BIT_MSB:`GSNCR_OTP_BIT_LSB];
  assign otp_bus.byte_sel =
    reg_wdata[`GSNCR_OTP_BYTE_MSB:`GSNCR_OTP_BYTE_LSB];

  gsncr_otp_bit_programmer #(
    .PROG_CYCLES(OTP_BIT_PROGRAMMER_CYCLES)
  ) u_otp (
    .ref_clk(ref_clk),
    .rst(rst),
    .bus(otp_bus)
  );

  assign otp_read_data = otp_bus.read_data;
  assign otp_busy = otp_bus.busy;

  // ========================================================================
  // read data
  logic [31:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] snap;

  // write-only registers and holes read as zero
  always_comb begin
    snap = 32'h0000_0000;
    snap[`GSNCR_PIN_MSB:0] = pins_s;
    snap[`GSNCR_VERSION_MSB:`GSNCR_VERSION_LSB] = VERSION_CODE;
    rdata_d = rdata_q;
    rvalid_d = reg_rd;
    if (reg_rd) begin
      unique case (reg_addr)
        `GSNCR_ADDR_STATUS_FLAGS: rdata_d = {29'h0000_0000, flags_q};
        `GSNCR_ADDR_UART_WR_CNT: rdata_d = {24'h00_0000, cnt_q};
        `GSNCR_ADDR_PIN_SNAP: rdata_d = snap;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rdata_valid = rvalid_q;

  // ========================================================================
  // checks
  chk_reset_state: assert property (
    @(posedge ref_clk) disable iff (rst)
    $past(rst) |-> flags_q == `GSNCR_FLAGS_RST && cnt_q == `GSNCR_CNT_RST
      && pol_q && node_addr_q == `GSNCR_NODE_ADDR_RST
  ) else $error("bank not at reset values after reset");

  chk_flag_clear: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_flags && reg_wdata[`GSNCR_FLAG_RESET] |=> !flags_q[`GSNCR_FLAG_RESET]
  ) else $error("write one did not clear reset flag");

  chk_zero_keeps: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_flags && !reg_wdata[`GSNCR_FLAG_RESET] && flags_q[`GSNCR_FLAG_RESET]
      |=> flags_q[`GSNCR_FLAG_RESET]
  ) else $error("write zero changed a flag");

  chk_drv_err_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    (flags_q[`GSNCR_FLAG_DRV_ERR] && !temp_low_s) || shutdown_s
      |=> flags_q[`GSNCR_FLAG_DRV_ERR]
  ) else $error("driver error flag lost while hot");

  chk_uv_latch: assert property (
    @(posedge ref_clk) disable iff (rst)
    cp_uv_s |=> flags_q[`GSNCR_FLAG_CP_UV] && !drv_en_q
  ) else $error("undervoltage not latched or driver on");

  chk_cnt_step: assert property (
    @(posedge ref_clk) disable iff (rst)
    reg_wr && uart_mode |=> cnt_q == 8'($past(cnt_q) + 8'h01)
  ) else $error("uart write counter did not step");

  chk_cnt_quiet: assert property (
    @(posedge ref_clk) disable iff (rst)
    !(reg_wr && uart_mode) |=> $stable(cnt_q)
  ) else $error("uart write counter moved without uart write");

  chk_eff_addr: assert property (
    @(posedge ref_clk) disable iff (rst)
    !$past(rst) |-> eff_addr_q == 8'($past(node_addr_q)
      + {7'h00, $past(inc_s)})
  ) else $error("effective address wrong");

  chk_pin_read: assert property (
    @(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == `GSNCR_ADDR_PIN_SNAP |=>
      reg_rdata_valid && reg_rdata[7:0] == $past(pins_s)
      && reg_rdata[`GSNCR_EXT_STEP_BIT] == $past(pins_s[6])
      && reg_rdata[31:24] == VERSION_CODE
  ) else $error("pin snapshot read wrong");

  chk_chain_pol: assert property (
    @(posedge ref_clk) disable iff (rst)
    uart_mode && wr_pol |-> ##2 chain_next_address_oe
      && chain_next_address_out == $past(reg_wdata[0], 2)
  ) else $error("chain output polarity not applied");

  chk_pulse_match: assert property (
    @(posedge ref_clk) disable iff (rst)
    !$past(rst) |-> second_diagnostic_output
      == ($past(actual_position) == $past(cmp_q))
  ) else $error("position pulse does not follow compare");

  chk_delay_map: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_node |-> ##2 reply_delay_bits
      == {$past(reg_wdata[11:9], 2), 4'h8}
  ) else $error("reply delay mapping wrong");
endmodule

// ---- gsncr_map.svh ----
// register offsets, field positions, reset values and counts for the bank
`ifndef GSNCR_MAP_SVH
`define GSNCR_MAP_SVH

// ==========================================================================
// register offsets on the serial register port
`define GSNCR_ADDR_W 7
`define GSNCR_ADDR_STATUS_FLAGS 7'h01
`define GSNCR_ADDR_UART_WR_CNT 7'h02
`define GSNCR_ADDR_NODE_CFG 7'h03
`define GSNCR_ADDR_PIN_SNAP 7'h04
`define GSNCR_ADDR_POS_CMP 7'h05
`define GSNCR_ADDR_OTP_BIT_PROGRAMMER 7'h06

// ==========================================================================
// status flag positions and reset values
`define GSNCR_FLAG_RESET 0
`define GSNCR_FLAG_DRV_ERR 1
`define GSNCR_FLAG_CP_UV 2
`define GSNCR_FLAGS_RST 3'h1
`define GSNCR_CNT_RST 8'h00
`define GSNCR_NODE_ADDR_RST 8'h00
`define GSNCR_DELAY_RST 4'h0
`define GSNCR_POLARITY_RST 1'h1
`define GSNCR_CMP_RST 32'h0000_0000

// ==========================================================================
// field positions
`define GSNCR_NODE_ADDR_MSB 7
`define GSNCR_DELAY_MSB 11
`define GSNCR_DELAY_LSB 8
`define GSNCR_POL_BIT 0
`define GSNCR_PIN_MSB 7
`define GSNCR_EXT_STEP_BIT 6
`define GSNCR_VERSION_MSB 31
`define GSNCR_VERSION_LSB 24
`define GSNCR_OTP_BIT_MSB 2
`define GSNCR_OTP_BIT_LSB 0
`define GSNCR_OTP_BYTE_MSB 5
`define GSNCR_OTP_BYTE_LSB 4
`define GSNCR_OTP_BYTE_USED 2'h0

// ==========================================================================
// counts
`define GSNCR_OTP_BIT_PROGRAMMER_CYCLES 16

`endif

// ---- gsncr_pkg.sv ----
// types shared by the configuration and status register bank
package gsncr_pkg;

  // ========================================================================
  // otp programmer states
  typedef enum logic [0:0] {
    GSNCR_OTP_IDLE,
    GSNCR_OTP_BURN
  } gsncr_otp_state_t;

endpackage

// ---- gsncr_otp_if.sv ----
// link between the register bank and its otp bit programmer
`timescale 1ns/10ps

interface gsncr_otp_if;
  logic prog_req;
  logic refresh_req;
  logic [2:0] bit_sel;
  logic [1:0] byte_sel;
  logic [7:0] read_data;
  logic busy;

  // ========================================================================
  // bank drives requests, programmer answers
  modport ctrl (
    output prog_req,
    output refresh_req,
    output bit_sel,
    output byte_sel,
    input read_data,
    input busy
  );
  modport otp (
    input prog_req,
    input refresh_req,
    input bit_sel,
    input byte_sel,
    output read_data,
    output busy
  );
endinterface

// ---- gsncr_otp_bit_programmer.sv ----
// one-bit-at-a-time otp programmer with read refresh
`timescale 1ns/10ps
`include "gsncr_map.svh"

module gsncr_otp_bit_programmer import gsncr_pkg::*; #(
  parameter int PROG_CYCLES = `GSNCR_OTP_BIT_PROGRAMMER_CYCLES,
  parameter logic [7:0] FUSE_INIT = 8'h00
) (
  input wire logic ref_clk,
  input wire logic rst,
  gsncr_otp_if.otp bus
);

  gsncr_otp_state_t state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic [2:0] sel_q, sel_d;
  logic [7:0] fuse_q, fuse_d;
  logic [7:0] rdata_q, rdata_d;

  // ========================================================================
  // next state: a burn holds for a fixed time, then sets exactly one fuse
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sel_d = sel_q;
    fuse_d = fuse_q;
    rdata_d = rdata_q;
    unique case (state_q)
      GSNCR_OTP_IDLE: begin
        // only byte zero exists; other bytes are ignored, not wrapped
        if (bus.prog_req && bus.byte_sel == `GSNCR_OTP_BYTE_USED) begin
          state_d = GSNCR_OTP_BURN;
          sel_d = bus.bit_sel;
          cnt_d = 8'h00;
        end else if (bus.refresh_req) begin
          rdata_d = fuse_q;
        end
      end
      GSNCR_OTP_BURN: begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_q == 8'(PROG_CYCLES - 1)) begin
          fuse_d[sel_q] = 1'b1;
          state_d = GSNCR_OTP_IDLE;
        end
      end
    endcase
  end

  // fuses model otp contents; a real array would not clear here
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= GSNCR_OTP_IDLE;
      cnt_q <= 8'h00;
      sel_q <= 3'h0;
      fuse_q <= FUSE_INIT;
      rdata_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sel_q <= sel_d;
      fuse_q <= fuse_d;
      rdata_q <= rdata_d;
    end
  end

  assign bus.read_data = rdata_q;
  assign bus.busy = (state_q != GSNCR_OTP_IDLE);

  // ========================================================================
  // checks
  chk_fuse_only_set: assert property (
    @(posedge ref_clk) disable iff (rst)
    ((~fuse_q) & $past(fuse_q)) == 8'h00
  ) else $error("otp fuse went back to zero");

  chk_refresh_copy: assert property (
    @(posedge ref_clk) disable iff (rst)
    bus.refresh_req && !bus.busy && !bus.prog_req |=>
      rdata_q == $past(fuse_q)
  ) else $error("otp read data not refreshed");
endmodule

// ---- gsncr_host.sv ----
// host model that drives the serial register port of the bank
`timescale 1ns/10ps
`include "gsncr_map.svh"

module gsncr_host (
  input wire logic ref_clk,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rdata_valid,
  output logic uart_mode,
  output logic reg_wr,
  output logic reg_rd,
  output logic [`GSNCR_ADDR_W-1:0] reg_addr,
  output logic [31:0] reg_wdata
);
  // ==========================================================================
  // host state; n_wr mirrors the writes sent in uart operation
  int n_wr = 0;
  initial begin
    uart_mode = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 32'h0000_0000;
  end

  // interface mode change, made off the access edges
  task automatic mode(input logic m);
    @(posedge ref_clk);
    uart_mode <= m;
  endtask

  // one write; the idle bus then shows the inverse, so stale data never
  // passes for fresh; callers keep test bit 17 at zero, and the otp byte too except in one burn check
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    if (uart_mode) begin
      n_wr++;
    end
  endtask

  // one read; the answer is taken once the valid pulse is seen
  task automatic rd(input logic [6:0] a, output logic [31:0] d,
                    output bit ok);
    ok = 1'b0;
    d = 32'h0000_0000;
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    // the strobe and address leave on the edge that took the request
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      if (reg_rdata_valid === 1'b1) begin
        ok = 1'b1;
        d = reg_rdata;
      end
    end
  endtask
endmodule

// ---- tb_top.sv ----
// self-checking testbench of the configuration and status register bank
`timescale 1ns/10ps
`include "gsncr_map.svh"

module tb_top;
  // ==========================================================================
  // clock, stimulus and observed signals
  localparam logic [7:0] VER = 8'h5A; // arbitrary version code
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] input_pins = 8'h00;
  logic inc_pin = 1'b0;
  logic shut = 1'b0;
  logic cool = 1'b0;
  logic cp_uv = 1'b0;
  logic [31:0] pos = 32'h0000_0000;
  logic uart_mode, reg_wr, reg_rd, valid, drv_en, chain_out, chain_oe;
  logic diag2, otp_busy;
  logic [6:0] reg_addr;
  logic [6:0] dly;
  logic [31:0] reg_wdata, rdata;
  logic [7:0] eff_addr, otp_rd;
  int err_count = 0;
  int n_compared = 0;

  // node config rows: written word, pin level, expected outputs
  typedef struct {
    logic [11:0] cfg;
    logic inc;
    logic [7:0] addr;
    logic [6:0] dly;
  } gsncr_row_t;
  gsncr_row_t rows [5] = '{
    '{12'h000, 1'b0, 8'h00, 7'h08},
    '{12'h305, 1'b0, 8'h05, 7'h18},
    '{12'hFFD, 1'b1, 8'hFE, 7'h78},
    '{12'h810, 1'b1, 8'h11, 7'h48},
    '{12'hB7F, 1'b0, 8'h7F, 7'h58}
  };

  always #20 ref_clk = ~ref_clk;

  gsncr_regs #(.VERSION_CODE(VER), .OTP_BIT_PROGRAMMER_CYCLES(2)) dut (
    .ref_clk(ref_clk), .rst(rst), .uart_mode(uart_mode),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(rdata), .reg_rdata_valid(valid),
    .input_pins(input_pins), .address_increment_pin(inc_pin),
    .driver_shutdown_event(shut), .temp_below_limit(cool),
    .charge_pump_undervoltage(cp_uv), .actual_position(pos),
    .uart_effective_address(eff_addr), .reply_delay_bits(dly),
    .driver_enable(drv_en), .chain_next_address_out(chain_out),
    .chain_next_address_oe(chain_oe),
    .second_diagnostic_output(diag2), .otp_read_data(otp_rd),
    .otp_busy(otp_busy)
  );

  gsncr_host host (
    .ref_clk(ref_clk), .reg_rdata(rdata), .reg_rdata_valid(valid),
    .uart_mode(uart_mode), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata)
  );

  // ==========================================================================
  // compare, read-and-compare and closing report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // a lost read answer ends the run at once
  task automatic rdc(input logic [6:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] d;
    bit ok;
    host.rd(a, d, ok);
    if (!ok) begin
      err_count++;
      stop_test();
    end
    chk(d & m, e);
  endtask

  // bounded wait for the otp programmer to finish
  task automatic otp_burn(input logic [2:0] b);
    host.wr(`GSNCR_ADDR_OTP_BIT_PROGRAMMER, {29'h0, b});
    #1;
    chk(32'(otp_busy), 32'h1);
    for (int i = 0; i < 20 && otp_busy !== 1'b0; i++) begin
      @(posedge ref_clk);
    end
    if (otp_busy !== 1'b0) begin
      err_count++;
      stop_test();
    end
    rdc(`GSNCR_ADDR_OTP_BIT_PROGRAMMER, 32'hFFFF_FFFF, 32'h0);
  endtask

  // ==========================================================================
  // main sequence: reset, table of node settings, then the awkward cases
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(32'(chain_out), 32'h1);
    chk(32'(chain_oe), 32'h0);
    rdc(`GSNCR_ADDR_STATUS_FLAGS, 32'hFFFF_FFFF, 32'h1);
    rdc(`GSNCR_ADDR_UART_WR_CNT, 32'hFFFF_FFFF, 32'h0);
    rdc(`GSNCR_ADDR_NODE_CFG, 32'hFFFF_FFFF, 32'h0);
    rdc(7'h07, 32'hFFFF_FFFF, 32'h0);
    host.mode(1'b1);
    // zero leaves the reset flag, one clears it
    host.wr(`GSNCR_ADDR_STATUS_FLAGS, 32'h0);
    rdc(`GSNCR_ADDR_STATUS_FLAGS, 32'hFFFF_FFFF, 32'h1);
    host.wr(`GSNCR_ADDR_STATUS_FLAGS, 32'h1);
    rdc(`GSNCR_ADDR_STATUS_FLAGS, 32'hFFFF_FFFF, 32'h0);
    rdc(`GSNCR_ADDR_UART_WR_CNT, 32'hFFFF_FFFF, 32'h2);
    rdc(`GSNCR_ADDR_UART_WR_CNT, 32'hFFFF_FFFF, 32'h2);
    foreach (rows[i]) begin
      inc_pin <= rows[i].inc;
      host.wr(`GSNCR_ADDR_NODE_CFG, {20'h0, rows[i].cfg});
      repeat (4) @(posedge ref_clk);
      chk(32'(eff_addr), 32'(rows[i].addr));
      chk(32'(dly), 32'(rows[i].dly));
    end
    // pin snapshot with version byte, then chain output polarity
    input_pins <= 8'h4C;
    repeat (4) @(posedge ref_clk);
    rdc(`GSNCR_ADDR_PIN_SNAP, 32'hFFFF_FFFF, {VER, 16'h0, 8'h4C});
    input_pins <= 8'hA5;
    host.wr(`GSNCR_ADDR_PIN_SNAP, 32'h0);
    repeat (3) @(posedge ref_clk);
    rdc(`GSNCR_ADDR_PIN_SNAP, 32'hFFFF_FFFF, {VER, 16'h0, 8'hA5});
    chk(32'({chain_out, chain_oe}), 32'h1);
    host.wr(`GSNCR_ADDR_PIN_SNAP, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(32'(chain_out), 32'h1);
    // shutdown flag only clears once cool
    shut <= 1'b1;
    repeat (5) @(posedge ref_clk);
    shut <= 1'b0;
    chk(32'(drv_en), 32'h0);
    host.wr(`GSNCR_ADDR_STATUS_FLAGS, 32'h2);
    rdc(`GSNCR_ADDR_STATUS_FLAGS, 32'hFFFF_FFFF, 32'h2);
    cool <= 1'b1;
    repeat (4) @(posedge ref_clk);
    host.wr(`GSNCR_ADDR_STATUS_FLAGS, 32'h2);
    rdc(`GSNCR_ADDR_STATUS_FLAGS, 32'hFFFF_FFFF, 32'h0);
    chk(32'(drv_en), 32'h1);
    // undervoltage blocks the driver while present, flag stays latched
    cp_uv <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk(32'(drv_en), 32'h0);
    cp_uv <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk(32'(drv_en), 32'h1);
    rdc(`GSNCR_ADDR_STATUS_FLAGS, 32'hFFFF_FFFF, 32'h4);
    host.wr(`GSNCR_ADDR_STATUS_FLAGS, 32'h4);
    rdc(`GSNCR_ADDR_STATUS_FLAGS, 32'hFFFF_FFFF, 32'h0);
    // position pulse follows equality
    host.wr(`GSNCR_ADDR_POS_CMP, 32'h1234_5678);
    pos <= 32'h1234_5678;
    repeat (3) @(posedge ref_clk);
    chk(32'(diag2), 32'h1);
    pos <= 32'h1234_5679;
    repeat (2) @(posedge ref_clk);
    chk(32'(diag2), 32'h0);
    // two single-bit burns, each seen after a refreshing read
    otp_burn(3'h3);
    chk(32'(otp_rd), 32'h08);
    // a nonzero byte field must burn nothing; the next read proves it
    host.wr(`GSNCR_ADDR_OTP_BIT_PROGRAMMER, 32'h0000_0015);
    #1;
    chk(32'(otp_busy), 32'h0);
    otp_burn(3'h0);
    chk(32'(otp_rd), 32'h09);
    rdc(`GSNCR_ADDR_UART_WR_CNT, 32'hFFFF_FFFF, 32'(host.n_wr));
    // spi writes leave the counter alone
    host.mode(1'b0);
    host.wr(7'h07, 32'h0);
    host.mode(1'b1);
    rdc(`GSNCR_ADDR_UART_WR_CNT, 32'hFFFF_FFFF, 32'(host.n_wr));
    while (host.n_wr != 255) begin
      host.wr(7'h07, 32'h0);
    end
    rdc(`GSNCR_ADDR_UART_WR_CNT, 32'hFFFF_FFFF, 32'hFF);
    host.wr(7'h07, 32'h0);
    rdc(`GSNCR_ADDR_UART_WR_CNT, 32'hFFFF_FFFF, 32'h0);
    // second reset in mid-run
    host.wr(`GSNCR_ADDR_PIN_SNAP, 32'h0);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    host.n_wr = 0;
    repeat (2) @(posedge ref_clk);
    chk(32'(chain_out), 32'h1);
    rdc(`GSNCR_ADDR_STATUS_FLAGS, 32'hFFFF_FFFF, 32'h1);
    rdc(`GSNCR_ADDR_UART_WR_CNT, 32'hFFFF_FFFF, 32'h0);
    stop_test();
  end
endmodule
